// ### rtl/wptc_top.sv
// Top: low-power wake control, turns tally and AXI4-Lite register slave.
// Assumes a 100 MHz clock; serial pins and the wake code are asynchronous.
//
// Contract
// RULE_01: Wake above rising level forces awake state
// RULE_02: Wake held high keeps device awake
// RULE_03: No angle output; continuous tally while wake held
// RULE_04: Rising level 300 to 650 mV, 50 mV steps
// RULE_05: Hysteresis 50/150/300/400 mV, falling floor 100 mV
// RULE_06: Count in 45 or 180 degree steps
// RULE_07: Tally saturates at mode limits
// RULE_08: Saturation flag sticky until tally reset
// RULE_09: Each sample adds change from previous sample
// RULE_10: Change of 180 or more counts reversed
// RULE_11: Change over 135 degrees sets step flag
// RULE_12: Reset command restarts tally at current angle
// RULE_13: Host idles serial pins 64 us for low power
// RULE_14: Sleep only when slow and wake low
// RULE_15: Sleep ends on timer or wake
// RULE_16: Sleep period programmable 8.192 to 524 ms
// RULE_17: Step flag sticky until tally reset
`timescale 1ns/10ps
module wptc_top import wptc_pkg::*; #(
	parameter int IDLE_CYC   = SERIAL_IDLE_CYC,
	parameter int AWAKE_CYC  = AWAKE_TIME_CYC,
	parameter int SLEEP_UNIT = SLEEP_BASE_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        rx_data_i,
	input  wire logic        ser_clk_i,
	input  wire logic        sel_n_i,
	input  wire logic [9:0]  wake_mv_i,
	input  wire logic [11:0] low_power_angle_path_i,
	input  wire logic        angle_strobe_i,
	output logic             path_on_o,
	output logic [11:0]      angle_o,
	output logic             angle_valid_o,
	output logic             lpm_o,
	output logic             irq_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic               awready;
		logic               wready;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               aw_got;
		logic               w_got;
		logic [7:0]         aw_addr;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic               arready;
		logic               rvalid;
		logic [1:0]         rresp;
		logic [31:0]        rdata;
		logic [31:0]        cfg;
		logic [IRQ_W-1:0]   irq_st;
		logic [IRQ_W-1:0]   irq_msk;
		logic               irq;
		logic               tc_clr;
		logic [2:0]         ser_s1;
		logic [2:0]         ser_s2;
		logic [15:0]        idle_cnt;
		wptc_lpm_e          lpm;
		logic [31:0]        lpm_cnt;
		logic               fast;
		logic               smp_d;
		logic               path_on;
		logic               lpm_on;
		logic [11:0]        angle;
		logic               angle_valid;
	} wptc_top_s;

	wptc_top_s   s;
	wptc_top_s   next_s;
	logic        wake_high;
	logic        wake_rise;
	logic        serial_idle;
	logic [31:0] sleep_cyc;
	logic [31:0] rd;
	logic        rd_ok;

	wptc_tc_if tc ();

	wptc_wake_cmp u_wake (
		.clk_i      (clk_i),
		.reset_n_i  (reset_n_i),
		.wake_mv_i  (wake_mv_i),
		.rise_sel_i (s.cfg[CFG_RISE_LSB +: 3]),
		.hys_sel_i  (s.cfg[CFG_HYS_LSB +: 2]),
		.high_o     (wake_high),
		.rise_o     (wake_rise)
	);

	wptc_turns u_turns (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.tc        (tc.acc)
	);

	// Samples only count while the low-power path is powered
	assign tc.sample = angle_strobe_i && s.path_on; // [RULE_09]
	assign tc.angle  = low_power_angle_path_i;
	assign tc.step45 = s.cfg[CFG_STEP45];
	assign tc.clr    = s.tc_clr;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_s      = s;
		serial_idle = (s.ser_s2 == 3'h0);
		sleep_cyc   = 32'(int'(s.cfg[CFG_SLEEP_LSB +: 6]) + 1) * 32'(SLEEP_UNIT); // [RULE_16]
		rd          = 32'h0000_0000;
		rd_ok       = 1'b1;

		// Pin synchronisers
		next_s.ser_s1 = {rx_data_i, ser_clk_i, sel_n_i};
		next_s.ser_s2 = s.ser_s1;

		// AXI write channel
		next_s.tc_clr = 1'b0;
		if (s_axi_awvalid_i && s.awready) begin
			next_s.aw_got  = 1'b1;
			next_s.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata_i;
			next_s.wstrb = s_axi_wstrb_i;
		end
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = 2'h0;
			case (s.aw_addr)
				ADDR_CFG: begin
					for (int b = 0; b < 4; b++) begin
						if (s.wstrb[b]) begin
							next_s.cfg[b*8 +: 8] = s.wdata[b*8 +: 8];
						end
					end
				end
				ADDR_IRQ_ST: begin
					if (s.wstrb[0]) begin
						next_s.irq_st = s.irq_st & ~s.wdata[IRQ_W-1:0];
					end
				end
				ADDR_IRQ_MSK: begin
					if (s.wstrb[0]) begin
						next_s.irq_msk = s.wdata[IRQ_W-1:0];
					end
				end
				ADDR_CMD: begin
					next_s.tc_clr = s.wstrb[0] && (s.wdata[3:0] == CMD_TC_RESET); // [RULE_12]
				end
				ADDR_TALLY, ADDR_WARN: begin
					next_s.bresp = 2'h0;
				end
				default: begin
					next_s.bresp = 2'h3;
				end
			endcase
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready  = !next_s.w_got && !next_s.bvalid;

		// AXI read channel
		case (s_axi_araddr_i)
			ADDR_CFG:     rd = s.cfg;
			ADDR_TALLY:   rd = {13'h0000, wake_high, s.lpm, 4'h0, tc.count};
			ADDR_IRQ_ST:  rd = {29'h0000_0000, s.irq_st};
			ADDR_IRQ_MSK: rd = {29'h0000_0000, s.irq_msk};
			ADDR_CMD:     rd = 32'h0000_0000;
			ADDR_WARN: begin
				rd[WARN_SAT_BIT]  = tc.sat; // [RULE_08]
				rd[WARN_JUMP_BIT] = tc.jump; // [RULE_11]
			end
			default:      rd_ok = 1'b0;
		endcase
		if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd;
			next_s.rresp  = rd_ok ? 2'h0 : 2'h3;
		end
		next_s.arready = !next_s.rvalid;

		// Interrupts: set wins over a same-cycle clear
		next_s.irq_st[IRQ_SAT]  = next_s.irq_st[IRQ_SAT] || tc.sat_ev;
		next_s.irq_st[IRQ_JUMP] = next_s.irq_st[IRQ_JUMP] || tc.jump_ev;
		next_s.irq_st[IRQ_WAKE] = next_s.irq_st[IRQ_WAKE] || (wake_rise && s.lpm != WPTC_NORMAL);
		next_s.irq = |(next_s.irq_st & next_s.irq_msk);

		// Low-power sequencing
		if (!serial_idle) begin
			next_s.idle_cnt = '0;
		end else if (s.idle_cnt < 16'(IDLE_CYC)) begin
			next_s.idle_cnt = s.idle_cnt + 16'h0001;
		end
		// Magnitude is registered, so judge it one cycle after its sample
		next_s.smp_d = tc.sample;
		if (s.smp_d && tc.delta_mag > s.cfg[CFG_VEL_LSB +: 12]) begin // [RULE_14]
			next_s.fast = 1'b1;
		end
		next_s.lpm_cnt = s.lpm_cnt + 32'h0000_0001;
		case (s.lpm)
			WPTC_NORMAL: begin
				if (s.cfg[CFG_LPM_EN] && s.idle_cnt >= 16'(IDLE_CYC)) begin // [RULE_13]
					next_s.lpm     = WPTC_AWAKE;
					next_s.lpm_cnt = '0;
					next_s.fast    = 1'b0;
				end
			end
			WPTC_AWAKE: begin
				if (s.lpm_cnt >= 32'(AWAKE_CYC - 1)) begin
					next_s.lpm_cnt = '0;
					next_s.fast    = 1'b0;
					// Held wake keeps the path sampling back to back
					if (!wake_high && !s.fast) begin // [RULE_02] [RULE_14]
						next_s.lpm = WPTC_SLEEP;
					end
				end
			end
			WPTC_SLEEP: begin
				if (wake_high || s.lpm_cnt >= sleep_cyc - 32'h0000_0001) begin // [RULE_01] [RULE_15]
					next_s.lpm     = WPTC_AWAKE;
					next_s.lpm_cnt = '0;
					next_s.fast    = 1'b0;
				end
			end
			default: begin
				next_s.lpm = WPTC_NORMAL;
			end
		endcase
		if (!serial_idle || !s.cfg[CFG_LPM_EN]) begin
			next_s.lpm = WPTC_NORMAL;
		end
		next_s.path_on = next_s.lpm != WPTC_SLEEP;
		next_s.lpm_on  = next_s.lpm != WPTC_NORMAL;

		// Angle output only in normal operation
		next_s.angle_valid = 1'b0;
		if (s.lpm == WPTC_NORMAL && angle_strobe_i) begin // [RULE_03]
			next_s.angle       = low_power_angle_path_i;
			next_s.angle_valid = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s         <= '0;
			s.cfg     <= CFG_RESET;
			s.lpm     <= WPTC_NORMAL;
			s.path_on <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready_o = s.awready;
	assign s_axi_wready_o  = s.wready;
	assign s_axi_bresp_o   = s.bresp;
	assign s_axi_bvalid_o  = s.bvalid;
	assign s_axi_arready_o = s.arready;
	assign s_axi_rdata_o   = s.rdata;
	assign s_axi_rresp_o   = s.rresp;
	assign s_axi_rvalid_o  = s.rvalid;
	assign path_on_o       = s.path_on;
	assign angle_o         = s.angle;
	assign angle_valid_o   = s.angle_valid;
	assign lpm_o           = s.lpm_on;
	assign irq_o           = s.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_WAKE_EXIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_01]
		s.lpm == WPTC_SLEEP && wake_high && serial_idle && s.cfg[CFG_LPM_EN]
		|=> s.lpm == WPTC_AWAKE ##1 path_on_o)
		else $error("wake did not end sleep");
	AST_WAKE_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_02]
		s.lpm == WPTC_AWAKE && wake_high |=> s.lpm != WPTC_SLEEP)
		else $error("slept with wake high");
	AST_NO_ANGLE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_03]
		angle_valid_o |-> $past(s.lpm) == WPTC_NORMAL)
		else $error("angle produced in low power");
	AST_SLEEP_COND: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_14]
		s.lpm == WPTC_AWAKE ##1 s.lpm == WPTC_SLEEP |-> !$past(wake_high) && !$past(s.fast))
		else $error("sleep entered while fast or wake high");
	AST_SLEEP_LEN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_15]
		s.lpm == WPTC_SLEEP |-> s.lpm_cnt < sleep_cyc)
		else $error("sleep overran its period");
	AST_IDLE_ENTRY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_13]
		$past(s.lpm) == WPTC_NORMAL && s.lpm == WPTC_AWAKE |-> $past(s.idle_cnt) >= IDLE_CYC)
		else $error("low power entered early");
	AST_IRQ: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		irq_o == |(s.irq_st & s.irq_msk))
		else $error("interrupt level mismatch");
	COV_SLEEP: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		s.lpm == WPTC_AWAKE ##1 s.lpm == WPTC_SLEEP);
	COV_WAKE: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		s.lpm == WPTC_SLEEP && wake_high);
	COV_CLR: cover property (@(posedge clk_i) disable iff (!reset_n_i) s.tc_clr);
endmodule

// ### rtl/wptc_pkg.sv
// Package: constants, register map and state types of the wake pin turns counter.
// Assumes a 100 MHz system clock; the RTL modules and the testbench import it whole.
package wptc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SERIAL_IDLE_US  = 64;
	localparam int AWAKE_TIME_US   = 160;
	localparam int SLEEP_BASE_US   = 8192;
	localparam int SERIAL_IDLE_CYC = (SERIAL_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AWAKE_TIME_CYC  = (AWAKE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int SLEEP_BASE_CYC  = (SLEEP_BASE_US * 1000) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Register map (byte addresses; two registers given by word index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_CMD      = 8'h1E;
	localparam logic [7:0] IDX_WARN     = 8'h26;
	localparam logic [7:0] ADDR_CFG     = 8'h00;
	localparam logic [7:0] ADDR_TALLY   = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
	localparam logic [7:0] ADDR_CMD     = 8'(IDX_CMD * 4);
	localparam logic [7:0] ADDR_WARN    = 8'(IDX_WARN * 4);

	// Configuration fields
	localparam int CFG_RISE_LSB  = 0;
	localparam int CFG_HYS_LSB   = 4;
	localparam int CFG_STEP45    = 6;
	localparam int CFG_LPM_EN    = 7;
	localparam int CFG_SLEEP_LSB = 8;
	localparam int CFG_VEL_LSB   = 16;
	localparam logic [31:0] CFG_RESET = 32'h0200_00C0;

	// Command and warning fields
	localparam logic [3:0] CMD_TC_RESET = 4'h2;
	localparam int WARN_SAT_BIT  = 0;
	localparam int WARN_JUMP_BIT = 3;

	// Interrupt status bits
	localparam int IRQ_SAT  = 0;
	localparam int IRQ_JUMP = 1;
	localparam int IRQ_WAKE = 2;
	localparam int IRQ_W    = 3;

	// ------------------------------------------------------------
	// Wake comparator levels in mV
	// ------------------------------------------------------------
	localparam logic [9:0] WAKE_RISE_BASE_MV = 10'h12C;
	localparam logic [9:0] WAKE_RISE_STEP_MV = 10'h032;
	localparam logic [9:0] WAKE_FALL_MIN_MV  = 10'h064;
	localparam logic [9:0] HYS_MV0           = 10'h032;
	localparam logic [9:0] HYS_MV1           = 10'h096;
	localparam logic [9:0] HYS_MV2           = 10'h12C;
	localparam logic [9:0] HYS_MV3           = 10'h190;

	// ------------------------------------------------------------
	// Turns counting: 12-bit angle, 45 deg = 512 codes
	// ------------------------------------------------------------
	localparam logic [11:0] JUMP_LIMIT = 12'h600;
	localparam logic [21:0] POS_MAX    = 22'h0F_FFFF;
	localparam logic [21:0] POS_MIN    = 22'h30_0000;

	typedef enum logic [1:0] {WPTC_NORMAL, WPTC_AWAKE, WPTC_SLEEP} wptc_lpm_e;

endpackage

// ### rtl/wptc_tc_if.sv
// Interface: link between the low-power control and the turns accumulator.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface wptc_tc_if;
	logic        sample;
	logic [11:0] angle;
	logic        step45;
	logic        clr;
	logic [11:0] count;
	logic [11:0] delta_mag;
	logic        sat;
	logic        jump;
	logic        sat_ev;
	logic        jump_ev;
	modport ctrl (output sample, angle, step45, clr,
		input count, delta_mag, sat, jump, sat_ev, jump_ev);
	modport acc  (input sample, angle, step45, clr,
		output count, delta_mag, sat, jump, sat_ev, jump_ev);
endinterface

// ### rtl/wptc_wake_cmp.sv
// Wake input comparator with programmable rising level and hysteresis.
// Assumes wake_mv_i is a converter code in mV from another domain.
`timescale 1ns/10ps
module wptc_wake_cmp import wptc_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic [9:0] wake_mv_i,
	input  wire logic [2:0] rise_sel_i,
	input  wire logic [1:0] hys_sel_i,
	output logic            high_o,
	output logic            rise_o
);
	typedef struct packed {
		logic [9:0] s1;
		logic [9:0] s2;
		logic       high;
		logic       rise;
	} wptc_wk_s;

	wptc_wk_s   s;
	wptc_wk_s   next_s;
	logic [9:0] rise_mv;
	logic [9:0] hys_mv;
	logic [9:0] fall_mv;

	// Code may tear across the sync; a single bad sample past a level flips high at once
	always_comb begin
		rise_mv = WAKE_RISE_BASE_MV + 10'(rise_sel_i * WAKE_RISE_STEP_MV); // [RULE_04]
		case (hys_sel_i)
			2'h0:    hys_mv = HYS_MV0;
			2'h1:    hys_mv = HYS_MV1;
			2'h2:    hys_mv = HYS_MV2;
			default: hys_mv = HYS_MV3;
		endcase
		fall_mv = (rise_mv < hys_mv + WAKE_FALL_MIN_MV) ? WAKE_FALL_MIN_MV
			: rise_mv - hys_mv; // [RULE_05]
		next_s    = s;
		next_s.s1 = wake_mv_i;
		next_s.s2 = s.s1;
		if (!s.high && s.s2 > rise_mv) begin
			next_s.high = 1'b1;
		end else if (s.high && s.s2 < fall_mv) begin
			next_s.high = 1'b0;
		end
		next_s.rise = next_s.high && !s.high;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign high_o = s.high;
	assign rise_o = s.rise;

	AST_WK_RISE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_04]
		$rose(s.high) |-> $past(s.s2) > $past(rise_mv))
		else $error("wake rose below rising level");
	AST_WK_FALL: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_05]
		$fell(s.high) |-> ($past(s.s2) < $past(fall_mv) && $past(fall_mv) >= WAKE_FALL_MIN_MV))
		else $error("wake fell above falling level");
endmodule

// ### rtl/wptc_turns.sv
// Turns accumulator: signed tally from successive low-power angles.
// Assumes samples arrive as one-cycle strobes on the shared clock.
`timescale 1ns/10ps
module wptc_turns import wptc_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_n_i,
	wptc_tc_if.acc   tc
);
	typedef struct packed {
		logic signed [21:0] pos;
		logic [11:0]        prev;
		logic [11:0]        mag;
		logic               primed;
		logic               sat;
		logic               jump;
		logic               sat_ev;
		logic               jump_ev;
	} wptc_tc_s;

	wptc_tc_s           s;
	wptc_tc_s           next_s;
	logic signed [11:0] delta;
	logic signed [22:0] sum;
	logic               set_sat;
	logic               set_jump;

	always_comb begin
		next_s   = s;
		delta    = signed'(tc.angle - s.prev); // [RULE_10]
		sum      = 23'(s.pos) + 23'(delta);
		set_sat  = 1'b0;
		set_jump = 1'b0;
		next_s.sat_ev  = 1'b0;
		next_s.jump_ev = 1'b0;
		if (tc.clr) begin
			next_s.pos    = '0; // [RULE_12]
			next_s.prev   = tc.angle;
			next_s.primed = 1'b1;
		end else if (tc.sample) begin // [RULE_09]
			next_s.prev   = tc.angle;
			next_s.primed = 1'b1;
			if (s.primed) begin
				next_s.mag = delta[11] ? 12'(-delta) : 12'(delta);
				set_jump   = next_s.mag > JUMP_LIMIT; // [RULE_11]
				if (sum > 23'(signed'(POS_MAX))) begin
					next_s.pos = POS_MAX; // [RULE_07]
					set_sat    = 1'b1;
				end else if (sum < 23'(signed'(POS_MIN))) begin
					next_s.pos = POS_MIN;
					set_sat    = 1'b1;
				end else begin
					next_s.pos = sum[21:0];
				end
			end
		end
		// Clear wins: a sample in the clearing cycle is dropped and sets no flag
		next_s.sat  = (s.sat && !tc.clr) || set_sat; // [RULE_08]
		next_s.jump = (s.jump && !tc.clr) || set_jump; // [RULE_17]
		next_s.sat_ev  = set_sat;
		next_s.jump_ev = set_jump;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Same limit in both modes: only the scale differs
	assign tc.count     = tc.step45 ? s.pos[20:9] : {{2{s.pos[21]}}, s.pos[20:11]}; // [RULE_06]
	assign tc.delta_mag = s.mag;
	assign tc.sat       = s.sat;
	assign tc.jump      = s.jump;
	assign tc.sat_ev    = s.sat_ev;
	assign tc.jump_ev   = s.jump_ev;

	AST_TC_LIMIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_07]
		(s.pos <= signed'(POS_MAX)) && (s.pos >= signed'(POS_MIN)))
		else $error("tally beyond limit");
	AST_TC_STICKY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_08]
		s.sat && !tc.clr |=> s.sat)
		else $error("saturation flag dropped without reset");
	AST_TC_JUMP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_11]
		tc.sample && !tc.clr && s.primed && (delta > 12'sd1536 || delta < -12'sd1536)
		|=> s.jump && s.jump_ev)
		else $error("large step not flagged");
	AST_TC_CLR: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE_12]
		tc.clr |=> (s.pos == 0) && (s.prev == $past(tc.angle)))
		else $error("tally not restarted at current angle");
	COV_TC_SAT: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(s.sat));
endmodule

// ### bench/wptc_motor_model.sv
// Far-side model: filtered back-EMF level, low-power angle source, host serial pins.
// Assumes calls are made just after a rising edge of clk_i.
`timescale 1ns/10ps
module wptc_motor_model (
	input  wire logic   clk_i,
	output logic [9:0]  wake_mv_o,
	output logic [11:0] angle_o,
	output logic        strobe_o,
	output logic [2:0]  serial_o
);
	initial begin
		wake_mv_o = 10'h000;
		angle_o   = 12'h000;
		strobe_o  = 1'b0;
		serial_o  = 3'h7;
	end
	// One sample a strobe, wrapping like the sensor angle
	task step(input logic [11:0] d);
		angle_o  <= angle_o + d;
		strobe_o <= 1'b1;
		@(posedge clk_i);
		strobe_o <= 1'b0;
		@(posedge clk_i);
	endtask
	// All pins low long enough starts low power; any high ends it
	task serial(input logic [2:0] v);
		serial_o <= v;
	endtask
	task wake(input logic [9:0] mv);
		wake_mv_o <= mv;
	endtask
endmodule

// ### bench/wake_pin_turns_counter_test.sv
// Testbench: AXI4-Lite register access and turns/wake scenarios on wptc_top.
// Assumes shortened timing parameters; all five AXI channels are driven.
`timescale 1ns/10ps
module wake_pin_turns_counter_test;
	import wptc_pkg::*;
	logic clk_i = 1'b0, reset_n_i = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic awready, wready, bvalid, arready, rvalid, path_on, angle_valid, lpm, irq;
	logic [2:0] ser;
	logic [3:0] strb = 4'hF;
	logic [1:0] bresp, rresp, r;
	logic [9:0] wake_mv;
	logic [11:0] angle, angle_out;
	logic strobe, bad_av = 1'b0;
	int fails = 0, checks_done = 0, i;
	wptc_motor_model i_wptc_motor_model (.clk_i(clk_i), .wake_mv_o(wake_mv), .angle_o(angle),
		.strobe_o(strobe), .serial_o(ser));
	wptc_top #(.IDLE_CYC(20), .AWAKE_CYC(10), .SLEEP_UNIT(30)) i_wptc_top (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.rx_data_i(ser[2]), .ser_clk_i(ser[1]),
		.sel_n_i(ser[0]), .wake_mv_i(wake_mv), .low_power_angle_path_i(angle),
		.angle_strobe_i(strobe), .path_on_o(path_on), .angle_o(angle_out),
		.angle_valid_o(angle_valid), .lpm_o(lpm), .irq_o(irq));
	initial forever #5 clk_i = ~clk_i;
	// Angle output must stay silent in low power
	always @(posedge clk_i) if (lpm === 1'b1 && angle_valid !== 1'b0) bad_av <= 1'b1;
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	// Readies are registered, so the level seen at the falling edge is the one sampled
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw, b;
		pa = 1'b0;
		pw = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk_i);
			b = bvalid;
			if (awvalid && awready) pa = 1'b1;
			if (wvalid && wready) pw = 1'b1;
			r = bresp;
			@(posedge clk_i);
			if (pa) awvalid <= 1'b0;
			if (pw) wvalid <= 1'b0;
		end while (!(b === 1'b1));
		bready <= 1'b0;
		// Idle edge: a next call must not relower and raise valids in one step
		@(posedge clk_i);
	endtask
	task rd(input logic [7:0] a);
		logic pa, v;
		pa = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk_i);
			if (arvalid && arready) pa = 1'b1;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_i);
			if (pa) arvalid <= 1'b0;
		end while (!(v === 1'b1));
		rready <= 1'b0;
		@(posedge clk_i);
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task rdchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(n, e, d & m);
	endtask
	task run(input int n, input logic [11:0] dl);
		for (i = 0; i < n; i++) i_wptc_motor_model.step(dl);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		summarize;
	end
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rdchk("cfg", ADDR_CFG, 32'hFFFFFFFF, CFG_RESET);
		rd(8'h40);
		chk("unmapped", 32'h3, {30'h0, r});
		wr(8'h40, 32'h0);
		chk("bresp", 32'h3, {30'h0, r});
		rdchk("warn", ADDR_WARN, 32'hFFFF, 32'h0);
		run(1, 12'h000);
		run(1, 12'h200);
		chk("angle", {20'h0, angle}, {20'h0, angle_out});
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h001);
		run(1, 12'h600);
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h004);
		rdchk("warn", ADDR_WARN, 32'hFFFF, 32'h0);
		run(1, 12'h800);
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h000);
		rdchk("warn", ADDR_WARN, 32'hFFFF, 32'h8);
		rdchk("irq_st", ADDR_IRQ_ST, 32'h7, 32'h2);
		wr(ADDR_IRQ_MSK, 32'h2);
		@(posedge clk_i);
		chk("irq", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_ST, 32'h2);
		@(posedge clk_i);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test warnings done");
		wr(ADDR_CMD, {28'h0, CMD_TC_RESET});
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h000);
		rdchk("warn", ADDR_WARN, 32'hFFFF, 32'h0);
		run(1, 12'h200);
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h001);
		strb <= 4'hE;
		wr(ADDR_CMD, {28'h0, CMD_TC_RESET});
		strb <= 4'hF;
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h001);
		wr(ADDR_CFG, 32'h02000000);
		wr(ADDR_CMD, {28'h0, CMD_TC_RESET});
		run(2, 12'h400);
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h001);
		run(1030, 12'h400);
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h1FF);
		rdchk("warn", ADDR_WARN, 32'hFFFF, 32'h1);
		wr(ADDR_CMD, {28'h0, CMD_TC_RESET});
		rdchk("warn", ADDR_WARN, 32'hFFFF, 32'h0);
		run(1030, 12'hC00);
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'hE00);
		$display("test tally done");
		// Rising level 400 mV, falling level 250 mV
		wr(ADDR_CFG, CFG_RESET | 32'h0000_0012);
		wr(ADDR_CMD, {28'h0, CMD_TC_RESET});
		i_wptc_motor_model.serial(3'h0);
		for (i = 0; i < 300 && path_on !== 1'b0; i++) @(posedge clk_i);
		rdchk("state", ADDR_TALLY, 32'h70000, 32'h20000);
		i_wptc_motor_model.wake(10'h1C2);
		for (i = 0; i < 12 && path_on !== 1'b1; i++) @(posedge clk_i);
		chk("path_on", 32'h1, {31'h0, path_on});
		rdchk("irq_wake", ADDR_IRQ_ST, 32'h4, 32'h4);
		run(1, 12'h200);
		rdchk("tally", ADDR_TALLY, 32'hFFF, 32'h001);
		i_wptc_motor_model.wake(10'h104);
		for (i = 0; i < 80 && path_on === 1'b1; i++) @(posedge clk_i);
		chk("hold", 32'h50, i);
		rdchk("state", ADDR_TALLY, 32'h70000, 32'h50000);
		i_wptc_motor_model.wake(10'h0C8);
		for (i = 0; i < 60 && path_on !== 1'b0; i++) @(posedge clk_i);
		chk("path_on", 32'h0, {31'h0, path_on});
		i_wptc_motor_model.serial(3'h2);
		repeat (6) @(posedge clk_i);
		chk("lpm", 32'h0, {31'h0, lpm});
		chk("angle_valid", 32'h0, {31'h0, bad_av});
		$display("test low power done");
		summarize;
	end
endmodule
